// >>> logic/serial_loader_params.svh
// Constants for the serial configuration loader: widths, depths, timing.
// Assumes a 125 MHz main clock; times are in ns and converted to cycles here.
`ifndef SERIAL_LOADER_PARAMS_SVH
`define SERIAL_LOADER_PARAMS_SVH

`define MCLK_PERIOD_NS      8
`define BYTE_BITS           8
`define FIFO_WORDS          8
`define FIFO_AFULL_MARGIN   2

// Init-ready is held low this long after reset (least time, rounded up)
`define INIT_HOLD_NS        1000
`define INIT_HOLD_CYCLES    ((`INIT_HOLD_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

// Half period of the generated configuration clock (least time, rounded up)
`define CFG_CLK_HALF_NS     40
`define CFG_CLK_HALF_CYCLES ((`CFG_CLK_HALF_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

// Configuration clock rising edges still driven after done goes high
`define POST_DONE_CLOCKS    8

`endif

// >>> logic/serial_loader_pkg.sv
// Types shared by the serial configuration loader modules.
// Assumes the constants header is included by the files that need numbers.
`default_nettype none

package serial_loader_pkg;

  typedef enum logic [2:0] {
    ST_RESET      = 3'b000,
    ST_INIT       = 3'b001,
    ST_WAIT_INIT  = 3'b010,
    ST_LOAD       = 3'b011,
    ST_FINISH     = 3'b100,
    ST_POST       = 3'b101,
    ST_CONFIGURED = 3'b110
  } load_state_type;

endpackage

`default_nettype wire

// >>> logic/byte_stream_if.sv
// Byte stream between the loader core and its FIFO.
// Assumes both ends run on the main clock.
`timescale 1ns/10ps
`default_nettype none

interface byte_stream_if #(
  parameter int WIDTH = 8
);
  logic [WIDTH-1:0] wr_data;
  logic             wr_valid;
  logic             wr_ready;
  logic             wr_afull;
  logic [WIDTH-1:0] rd_data;
  logic             rd_valid;
  logic             rd_ready;

  modport fifo (
    input  wr_data,
    input  wr_valid,
    output wr_ready,
    output wr_afull,
    output rd_data,
    output rd_valid,
    input  rd_ready
  );

  modport core (
    output wr_data,
    output wr_valid,
    input  wr_ready,
    input  wr_afull,
    input  rd_data,
    input  rd_valid,
    output rd_ready
  );
endinterface

`default_nettype wire

// >>> logic/byte_fifo.sv
// Byte FIFO with a registered output stage.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none

module byte_fifo
  import serial_loader_pkg::*;
#(
  parameter int WIDTH  = 8,
  parameter int DEPTH  = 8,
  parameter int MARGIN = 2
) (
  input  wire logic mclk_in,
  input  wire logic reset_in,
  byte_stream_if.fifo port
);

  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 4 || (1 << PW) != DEPTH || MARGIN < 1 || MARGIN >= DEPTH) begin : g_check
    $error("byte_fifo: DEPTH must be a power of two >= 4, MARGIN in 1..DEPTH-1");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             push;
  logic             pop;

  ////////////////////////////////////////////////////////////////////////////
  assign port.wr_ready = (count < (PW+1)'(DEPTH));
  assign port.wr_afull = (count >= (PW+1)'(DEPTH - MARGIN));
  assign push          = port.wr_valid && port.wr_ready;
  assign pop           = (count != '0) && (!port.rd_valid || port.rd_ready);

  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem[wr_ptr] <= port.wr_data;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // Output stage: refilled from memory when empty or taken
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      port.rd_valid <= 1'b0;
      port.rd_data  <= '0;
    end else if (pop) begin
      port.rd_valid <= 1'b1;
      port.rd_data  <= mem[rd_ptr];
    end else if (port.rd_ready) begin
      port.rd_valid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// >>> logic/serial_config_loader.sv
// Serial configuration loader: takes the bitstream one bit per
// configuration clock, packs it into bytes and hands them out via a FIFO.
// Assumes straps are steady at reset release and pins are wired open-drain
// outside with external pull-ups on init-ready and done.
//
// Operation
// - One bitstream bit taken on each configuration clock cycle.
// - Config clock is a driven output in master, an input in slave mode.
// - Bits arrive most significant first; first bit is top of byte one.
// - Master clock driven only from init-ready high until shortly after done.
// - Init-ready is open-drain two-way; done is open-drain two-way too.
// - Strap low enables user pull-ups; high tri-states user pins meanwhile.
`timescale 1ns/10ps
`default_nettype none
`include "serial_loader_params.svh"

module serial_config_loader
  import serial_loader_pkg::*;
#(
  parameter int FIFO_DEPTH = `FIFO_WORDS,
  parameter int INIT_HOLD  = `INIT_HOLD_CYCLES,
  parameter int HALF_CLK   = `CFG_CLK_HALF_CYCLES,
  parameter int POST_CLKS  = `POST_DONE_CLOCKS
) (
  input  wire logic       mclk_in,
  input  wire logic       reset_in,
  input  wire logic       master_mode_in,
  input  wire logic       pullup_during_config_n_in,
  input  wire logic       config_clock_in,
  output logic            config_clock_out,
  output logic            config_clock_oe_n_out,
  input  wire logic       serial_data_in,
  input  wire logic       init_ready_in,
  output logic            init_ready_out,
  output logic            init_ready_oe_n_out,
  input  wire logic       done_in,
  output logic            done_out,
  output logic            done_oe_n_out,
  input  wire logic       load_complete_in,
  output logic [7:0]      data_out,
  output logic            valid_out,
  input  wire logic       ready_in,
  output logic            overflow_out,
  output logic            configured_out,
  output logic            user_pullup_en_out,
  output logic            user_tristate_out
);

  if (INIT_HOLD < 1 || INIT_HOLD > 65536 || HALF_CLK < 3 || HALF_CLK > 256 ||
      POST_CLKS < 1 || POST_CLKS > 255 || FIFO_DEPTH < 4) begin : g_check
    $error("serial_config_loader: parameter out of range");
  end

  localparam int BB = `BYTE_BITS;

  load_state_type   state;
  logic [15:0]      timer;
  logic             mode_master;
  logic             strap_high;
  logic [5:0]       meta;
  logic [5:0]       sync;
  logic             load_en;
  logic             link_tog_seen;
  logic             config_clock;
  logic [7:0]       half_cnt;
  logic [7:0]       post_cnt;
  logic             rise_now;
  logic [BB-1:0]    m_shift;
  logic [2:0]       m_cnt;
  logic             m_byte;
  logic [BB-1:0]    m_byte_data;
  logic             s_byte;
  logic             drive_window;

  // Link-domain state; start values keep simulation defined before the
  // first link edge, which may come long after reset
  logic             en_meta  = 1'b0;
  logic             en_sync  = 1'b0;
  logic [BB-1:0]    s_shift  = '0;
  logic [2:0]       s_cnt    = '0;
  logic [BB-1:0]    s_hold   = '0;
  logic             s_tog    = 1'b0;

  byte_stream_if #(.WIDTH(BB)) stream ();

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for pins and the link toggle
  always_ff @(posedge mclk_in) begin
    meta <= {pullup_during_config_n_in, s_tog, done_in, init_ready_in, serial_data_in,
             master_mode_in};
    sync <= meta;
  end

  wire logic mode_sync = sync[0];
  wire logic data_sync = sync[1];
  wire logic init_sync = sync[2];
  wire logic done_sync = sync[3];
  wire logic tog_sync  = sync[4];
  wire logic strap_sync = sync[5];

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: slave mode shift register on the incoming clock
  always_ff @(posedge config_clock_in) begin
    en_meta <= load_en;
    en_sync <= en_meta;
  end

  always_ff @(posedge config_clock_in) begin
    if (!en_sync) begin
      s_cnt <= '0;
    end else begin
      s_shift <= {s_shift[BB-2:0], serial_data_in};
      s_cnt   <= s_cnt + 1'b1;
      if (s_cnt == 3'(BB - 1)) begin
        s_hold <= {s_shift[BB-2:0], serial_data_in};
        s_tog  <= ~s_tog;
      end
    end
  end

  // Held byte stays steady for 8 link clocks, far longer than the sync delay
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      link_tog_seen <= 1'b0;
    end else begin
      link_tog_seen <= tog_sync;
    end
  end

  assign s_byte = (tog_sync != link_tog_seen) && !mode_master && (state == ST_LOAD);

  ////////////////////////////////////////////////////////////////////////////
  // Control sequence
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state    <= ST_RESET;
      timer    <= '0;
      post_cnt <= '0;
    end else begin
      unique case (state)
        ST_RESET: begin
          timer <= '0;
          state <= ST_INIT;
        end
        ST_INIT: begin
          timer <= timer + 1'b1;
          if (timer == 16'(INIT_HOLD - 1)) begin
            state <= ST_WAIT_INIT;
          end
        end
        ST_WAIT_INIT: begin
          if (init_sync) begin
            state <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (load_complete_in) begin
            state <= ST_FINISH;
          end
        end
        ST_FINISH: begin
          post_cnt <= '0;
          if (done_sync) begin
            state <= mode_master ? ST_POST : ST_CONFIGURED;
          end
        end
        ST_POST: begin
          if (rise_now) begin
            post_cnt <= post_cnt + 1'b1;
          end
          if (post_cnt == 8'(POST_CLKS)) begin
            state <= ST_CONFIGURED;
          end
        end
        ST_CONFIGURED: begin
          state <= ST_CONFIGURED;
        end
        default: begin
          state <= ST_RESET;
        end
      endcase
    end
  end

  // Straps caught once, after reset release
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      mode_master <= 1'b0;
      strap_high  <= 1'b0;
    end else if (state == ST_RESET) begin
      mode_master <= mode_sync;
      strap_high  <= strap_sync;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      load_en <= 1'b0;
    end else begin
      load_en <= (state == ST_WAIT_INIT) || (state == ST_LOAD);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master mode clock generator; holds low while the FIFO is nearly full in the load state
  assign drive_window = mode_master &&
                        ((state == ST_LOAD) || (state == ST_FINISH) || (state == ST_POST));
  assign rise_now     = drive_window && !config_clock && (half_cnt == 8'(HALF_CLK - 1)) &&
                        !((state == ST_LOAD) && stream.wr_afull);

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      config_clock     <= 1'b0;
      half_cnt <= '0;
    end else if (!drive_window) begin
      config_clock     <= 1'b0;
      half_cnt <= '0;
    end else if (half_cnt != 8'(HALF_CLK - 1)) begin
      half_cnt <= half_cnt + 1'b1;
    end else if (config_clock) begin
      config_clock     <= 1'b0;
      half_cnt <= '0;
    end else if (rise_now) begin
      config_clock     <= 1'b1;
      half_cnt <= '0;
    end
  end

  // Master mode bit capture: synced data reflects the pin before the rise
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      m_cnt       <= '0;
      m_shift     <= '0;
      m_byte      <= 1'b0;
      m_byte_data <= '0;
    end else begin
      m_byte <= 1'b0;
      if (state != ST_LOAD) begin
        m_cnt <= '0;
      end else if (rise_now) begin
        m_shift <= {m_shift[BB-2:0], data_sync};
        m_cnt   <= m_cnt + 1'b1;
        if (m_cnt == 3'(BB - 1)) begin
          m_byte      <= 1'b1;
          m_byte_data <= {m_shift[BB-2:0], data_sync};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte hand-off into the FIFO; a slave byte with no room is dropped
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      stream.wr_valid <= 1'b0;
      stream.wr_data  <= '0;
      overflow_out    <= 1'b0;
    end else begin
      stream.wr_valid <= 1'b0;
      if (m_byte || s_byte) begin
        if (stream.wr_ready) begin
          stream.wr_valid <= 1'b1;
          stream.wr_data  <= mode_master ? m_byte_data : s_hold;
        end else begin
          overflow_out <= 1'b1;
        end
      end
    end
  end

  assign stream.rd_ready = ready_in;
  assign data_out        = stream.rd_data;
  assign valid_out       = stream.rd_valid;

  byte_fifo #(
    .WIDTH  (BB),
    .DEPTH  (FIFO_DEPTH),
    .MARGIN (`FIFO_AFULL_MARGIN)
  ) u_fifo (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .port     (stream.fifo)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      config_clock_out      <= 1'b0;
      config_clock_oe_n_out <= 1'b1;
    end else begin
      config_clock_out      <= config_clock;
      config_clock_oe_n_out <= !drive_window;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      init_ready_out      <= 1'b0;
      init_ready_oe_n_out <= 1'b0;
      done_out            <= 1'b0;
      done_oe_n_out       <= 1'b0;
    end else begin
      init_ready_out      <= 1'b0;
      init_ready_oe_n_out <= !((state == ST_RESET) || (state == ST_INIT));
      done_out            <= 1'b0;
      done_oe_n_out       <= (state == ST_FINISH) || (state == ST_POST) ||
                             (state == ST_CONFIGURED);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      configured_out     <= 1'b0;
      user_pullup_en_out <= 1'b0;
      user_tristate_out  <= 1'b1;
    end else begin
      configured_out     <= (state == ST_CONFIGURED);
      // Strap not yet caught in the reset state, so pull-ups stay off there
      user_pullup_en_out <= !strap_high && (state != ST_RESET) &&
                            (state != ST_CONFIGURED);
      user_tristate_out  <= (strap_high || state == ST_RESET) &&
                            (state != ST_CONFIGURED);
    end
  end

endmodule

`default_nettype wire

// >>> verif/loader_monitor.sv
// Checker on the loader's top ports.
// Assumes it is bound to serial_config_loader.
`timescale 1ns/10ps
`default_nettype none
module loader_monitor (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic master_mode_in,
  input wire logic pullup_during_config_n_in,
  input wire logic config_clock_out,
  input wire logic config_clock_oe_n_out,
  input wire logic init_ready_in,
  input wire logic init_ready_out,
  input wire logic done_in,
  input wire logic done_out,
  input wire logic configured_out,
  input wire logic user_pullup_en_out,
  input wire logic user_tristate_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  a_slave_clock_input: assert property (!master_mode_in |-> config_clock_oe_n_out)
    else $error("clock pin driven in slave mode");
  a_clock_after_init: assert property ($fell(config_clock_oe_n_out) |-> $past(init_ready_in))
    else $error("clock driven before init-ready high");
  a_clock_off_configured: assert property (configured_out && $past(configured_out)
    |-> config_clock_oe_n_out)
    else $error("clock still driven when configured");
  a_done_before_config: assert property ($rose(configured_out) |-> $past(done_in, 2))
    else $error("configured without done high");
  a_pins_drive_low: assert property (!init_ready_out && !done_out)
    else $error("open-drain pin driven high");
  a_user_pins_off: assert property (pullup_during_config_n_in && !configured_out
    |-> user_tristate_out)
    else $error("user pins not tri-stated");
  a_pullup_strap: assert property (user_pullup_en_out |-> !pullup_during_config_n_in)
    else $error("pull-ups on with strap high");
  a_clock_high_half: assert property ($rose(config_clock_out) && !done_in
    |-> config_clock_out[*5] ##1 !config_clock_out)
    else $error("clock high half not five cycles");
endmodule
bind serial_config_loader loader_monitor i_mon (.mclk_in, .reset_in, .master_mode_in,
  .pullup_during_config_n_in, .config_clock_out, .config_clock_oe_n_out, .init_ready_in,
  .init_ready_out, .done_in, .done_out, .configured_out, .user_pullup_en_out,
  .user_tristate_out);
`default_nettype wire

// >>> verif/bit_source.sv
// Far-side bitstream source: slave clock and data, or a PROM on the device clock.
// Assumes the bench fills q and calls the tasks.
`timescale 1ns/10ps
`default_nettype none
module bit_source (
  input  wire logic master_in,
  input  wire logic pin_clock_in,
  output logic      link_clock_out,
  output logic      data_out
);
  logic [7:0] q[$];
  logic [7:0] cur;
  int         pos;
  initial begin
    link_clock_out = 1'b0;
    data_out = 1'b0;
    pos = 0;
  end
  // Top bit of each byte first; empty queue gives a toggling line
  task automatic next_bit();
    if (pos > 0) begin
      pos--;
      data_out = cur[pos];
    end else if (q.size() > 0) begin
      cur = q.pop_front();
      pos = 7;
      data_out = cur[7];
    end else begin
      data_out = ~data_out;
    end
  endtask
  // Slave: source drives clock, data steady around each rise
  task automatic run_clock(input int n);
    for (int i = 0; i < n; i++) begin
      next_bit();
      #40 link_clock_out = 1'b1;
      #40 link_clock_out = 1'b0;
    end
    data_out = ~data_out;
  endtask
  always @(negedge pin_clock_in) begin
    if (master_in) begin
      next_bit();
    end
  end
endmodule
`default_nettype wire

// >>> verif/serial_config_loader_test.sv
// Bench for the serial loader: straps, slave load with overflow, master load.
// Assumes bit_source as far side and pull-ups on init-ready and done.
`timescale 1ns/10ps
`default_nettype none
module serial_config_loader_test;
  logic mclk_in, reset_in, master_mode_in, pullup_during_config_n_in;
  logic load_complete_in, ready_in, init_ready_out, init_ready_oe_n_out;
  logic config_clock_out, config_clock_oe_n_out, done_out, done_oe_n_out;
  logic valid_out, overflow_out, configured_out, user_pullup_en_out, user_tristate_out;
  logic [7:0] data_out;
  wire logic link_clock, config_clock_in, serial_data_in, init_ready_in, done_in;
  int miscompares = 0;
  int cmp_count = 0;
  logic [7:0] pat [11] = '{8'haa, 8'h35, 8'h01, 8'h80, 8'hff, 8'h00, 8'h5c, 8'hc3,
                           8'h7e, 8'h12, 8'h34};
  assign config_clock_in = config_clock_oe_n_out ? link_clock : config_clock_out;
  assign init_ready_in = init_ready_oe_n_out ? 1'b1 : init_ready_out;
  assign done_in = done_oe_n_out ? 1'b1 : done_out;
  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end
  serial_config_loader #(.INIT_HOLD(4)) i_dut (.mclk_in, .reset_in, .master_mode_in,
    .pullup_during_config_n_in, .config_clock_in, .config_clock_out,
    .config_clock_oe_n_out, .serial_data_in, .init_ready_in, .init_ready_out,
    .init_ready_oe_n_out, .done_in, .done_out, .done_oe_n_out, .load_complete_in,
    .data_out, .valid_out, .ready_in, .overflow_out, .configured_out,
    .user_pullup_en_out, .user_tristate_out);
  bit_source i_src (.master_in(master_mode_in), .pin_clock_in(config_clock_in),
    .link_clock_out(link_clock), .data_out(serial_data_in));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic give_up();
    miscompares++;
    report_and_stop();
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic do_reset(input logic m, input logic s);
    step(1);
    reset_in = 1'b1;
    master_mode_in = m;
    pullup_during_config_n_in = s;
    ready_in = 1'b0;
    step(5);
    check("reset tristate", user_tristate_out, 1'b1);
    check("reset clock oe_n", config_clock_oe_n_out, 1'b1);
    reset_in = 1'b0;
  endtask
  task automatic receive(input int n);
    int k;
    int t;
    k = 0;
    for (t = 0; k < n; t++) begin
      @(negedge mclk_in);
      if (valid_out === 1'b1 && ready_in === 1'b1) begin
        check("byte", data_out, pat[k]);
        k++;
      end
      if (t > 4000) give_up();
    end
  endtask
  task automatic finish_load();
    int t;
    step(1);
    load_complete_in = 1'b1;
    step(1);
    load_complete_in = 1'b0;
    for (t = 0; t < 4000 && configured_out !== 1'b1; t++) @(posedge mclk_in);
    if (t == 4000) give_up();
    step(2);
    check("clock oe_n", config_clock_oe_n_out, 1'b1);
    check("done pin", done_in, 1'b1);
    check("user tristate", user_tristate_out, 1'b0);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic test_straps();
    for (int s = 0; s < 2; s++) begin
      do_reset(1'b0, s[0]);
      step(2);
      check("pull-up enable", user_pullup_en_out, !s[0]);
      check("tristate", user_tristate_out, s[0]);
      check("init pin low", init_ready_in, 1'b0);
    end
  endtask
  task automatic test_slave();
    int t;
    do_reset(1'b0, 1'b0);
    for (t = 0; t < 400 && init_ready_in !== 1'b1; t++) @(posedge mclk_in);
    if (t == 400) give_up();
    #3 i_src.run_clock(2);
    for (int i = 0; i < 9; i++) i_src.q.push_back(pat[i]);
    i_src.run_clock(72);
    step(20);
    check("overflow early", overflow_out, 1'b0);
    check("slave clock oe_n", config_clock_oe_n_out, 1'b1);
    i_src.q.push_back(pat[9]);
    i_src.q.push_back(pat[10]);
    i_src.run_clock(16);
    step(20);
    check("overflow", overflow_out, 1'b1);
    ready_in = 1'b1;
    receive(9);
    step(3);
    check("drained", valid_out, 1'b0);
    finish_load();
  endtask
  task automatic test_master();
    do_reset(1'b1, 1'b1);
    for (int i = 0; i < 4; i++) i_src.q.push_back(pat[i]);
    i_src.next_bit();
    check("early clock oe_n", config_clock_oe_n_out, 1'b1);
    ready_in = 1'b1;
    receive(4);
    check("master clock oe_n", config_clock_oe_n_out, 1'b0);
    finish_load();
  endtask
  initial begin
    reset_in = 1'b1;
    master_mode_in = 1'b0;
    pullup_during_config_n_in = 1'b1;
    load_complete_in = 1'b0;
    ready_in = 1'b0;
    test_straps();
    test_slave();
    test_master();
    report_and_stop();
  end
endmodule
`default_nettype wire
